/* File: dcwd_decoder.sv */
// Purpose: turn the fieldbus command word into internal drive commands
// Assumes: all inputs but the asynchronous resetn synchronous to clk, word arrives with a one-cycle strobe
// Notes:   decoded outputs are registered, one cycle after their cause
//
// Behaviour
// - low sixteen bits pass through unchanged
// - bit0 requests stop, bit1 requests start
// - direction is bit2 xor reference sign
// - rising bit4 resets an active fault
// - bit5 picks second external location, gated
// - bit6 set disables run when bus-sourced
// - bits 7-9 request normal, emergency, freewheel
// - bits 7-9 clear use parameter stop mode
// - bit10 clear selects first ramp set
// - bit11 forces ramp output to zero
// - bit12 freezes ramp output
// - bit13 forces ramp input to zero
// - bit14 blocks switching to local control
// - bit16 requests bus command takeover
// - bit17 requests bus reference takeover
// - bits 22-25 stored as user flags
`timescale 1ns/100ps

module dcwd_decoder
    import dcwd_pkg::*;
#(
    parameter int WORD_W = `DCWD_WORD_W,
    parameter int DRV_W  = `DCWD_DRV_W
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              cmdWrite,
    input  wire logic [WORD_W-1:0] cmdWord,
    input  wire logic              referenceNegative,
    input  wire logic              faultActive,
    input  wire logic              locationFromBus,
    input  wire logic              runEnableFromBus,
    input  wire logic              runEnableOther,
    input  wire dcwd_stop_mode_t   paramStopMode,
    input  wire dcwd_ramp_set_t    otherRampSet,
    output logic [DRV_W-1:0]       driveCommandWord,
    output dcwd_cmd_t              driveCmd,
    output logic                   faultResetPulse,
    output logic [WORD_W-1:0]      storedWord
);

    // ==============================================================
    // stored command word
    logic [WORD_W-1:0] wordQ;
    logic [WORD_W-1:0] wordD;

    always_comb begin
        wordD = wordQ;
        if (cmdWrite) begin
            wordD = cmdWord;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wordQ <= `DCWD_WORD_RESET;
        end else begin
            wordQ <= wordD;
        end
    end

    // ==============================================================
    // stop mode selection
    // a fixed priority keeps the safest stop when the master sets several bits
    function automatic dcwd_stop_mode_t pickStopMode(
        input logic [WORD_W-1:0] w,
        input dcwd_stop_mode_t   param
    );
        dcwd_stop_mode_t m;
        m = param;
        if (w[`DCWD_BIT_FREEWHEEL]) begin
            m = DCWD_STOP_FREEWHEEL;
        end else if (w[`DCWD_BIT_EMERG_STOP]) begin
            m = DCWD_STOP_EMERGENCY_RAMP;
        end else if (w[`DCWD_BIT_NORMAL_STOP]) begin
            m = DCWD_STOP_NORMAL_RAMP;
        end
        return m;
    endfunction

    // ==============================================================
    // field helpers
    // location only follows the word when the bus owns the selection
    function automatic dcwd_location_t pickLocation(
        input logic [WORD_W-1:0] w,
        input logic              fromBus,
        input dcwd_location_t    held
    );
        dcwd_location_t loc;
        loc = held;
        if (fromBus) begin
            loc = w[`DCWD_BIT_SECOND_LOC] ? DCWD_LOC_SECOND : DCWD_LOC_FIRST;
        end
        return loc;
    endfunction

    // bit6 is a disable, so the enable is its inverse
    function automatic logic pickRunEnable(
        input logic [WORD_W-1:0] w,
        input logic              fromBus,
        input logic              other
    );
        logic en;
        en = other;
        if (fromBus) begin
            en = ~w[`DCWD_BIT_RUN_DISABLE];
        end
        return en;
    endfunction

    // set bit10 leaves the choice to the other ramp-set source
    function automatic dcwd_ramp_set_t pickRampSet(
        input logic [WORD_W-1:0] w,
        input dcwd_ramp_set_t    other
    );
        dcwd_ramp_set_t rs;
        rs = DCWD_RAMP_SET_FIRST;
        if (w[`DCWD_BIT_SECOND_RAMP]) begin
            rs = other;
        end
        return rs;
    endfunction

    // edge is judged between successive written words, so a repeated
    // write of a set bit does not retrigger the reset
    function automatic logic faultEdge(
        input logic              wr,
        input logic [WORD_W-1:0] newWord,
        input logic [WORD_W-1:0] oldWord,
        input logic              fault
    );
        return wr && newWord[`DCWD_BIT_FAULT_RESET] &&
               !oldWord[`DCWD_BIT_FAULT_RESET] && fault;
    endfunction

    // ==============================================================
    // drive command word
    // reserved bit3 rides along here but nothing below decodes it
    logic [DRV_W-1:0] drvD;
    logic [DRV_W-1:0] drvQ;

    always_comb begin
        drvD = wordD[DRV_W-1:0];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drvQ <= '0;
        end else begin
            drvQ <= drvD;
        end
    end

    // ==============================================================
    // stop and start requests
    // both are levels of the stored word; a word with both set is passed raw
    logic            stopReqD;
    logic            stopReqQ;
    logic            startReqD;
    logic            startReqQ;
    dcwd_stop_mode_t stopModeD;
    dcwd_stop_mode_t stopModeQ;

    always_comb begin
        stopReqD  = wordD[`DCWD_BIT_STOP];
        startReqD = wordD[`DCWD_BIT_START];
        stopModeD = pickStopMode(wordD, paramStopMode);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stopReqQ  <= 1'b0;
            startReqQ <= 1'b0;
            stopModeQ <= DCWD_STOP_NORMAL_RAMP;
        end else begin
            stopReqQ  <= stopReqD;
            startReqQ <= startReqD;
            stopModeQ <= stopModeD;
        end
    end

    // ==============================================================
    // direction, location and run enable
    // the location is held while another source owns the selection
    logic           reverseD;
    logic           reverseQ;
    dcwd_location_t locationD;
    dcwd_location_t locationQ;
    logic           runEnableD;
    logic           runEnableQ;

    always_comb begin
        reverseD   = wordD[`DCWD_BIT_REVERSE] ^ referenceNegative;
        locationD  = pickLocation(wordD, locationFromBus, locationQ);
        runEnableD = pickRunEnable(wordD, runEnableFromBus, runEnableOther);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reverseQ   <= 1'b0;
            locationQ  <= DCWD_LOC_FIRST;
            runEnableQ <= 1'b0;
        end else begin
            reverseQ   <= reverseD;
            locationQ  <= locationD;
            runEnableQ <= runEnableD;
        end
    end

    // ==============================================================
    // ramp generator controls
    // overrides are passed as levels; their precedence lies in the ramp logic
    dcwd_ramp_set_t rampSetD;
    dcwd_ramp_set_t rampSetQ;
    logic           rampOutZeroD;
    logic           rampOutZeroQ;
    logic           rampHoldD;
    logic           rampHoldQ;
    logic           rampInZeroD;
    logic           rampInZeroQ;

    always_comb begin
        rampSetD     = pickRampSet(wordD, otherRampSet);
        rampOutZeroD = wordD[`DCWD_BIT_RAMP_OUT_ZERO];
        rampHoldD    = wordD[`DCWD_BIT_RAMP_HOLD];
        rampInZeroD  = wordD[`DCWD_BIT_RAMP_IN_ZERO];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rampSetQ     <= DCWD_RAMP_SET_FIRST;
            rampOutZeroQ <= 1'b0;
            rampHoldQ    <= 1'b0;
            rampInZeroQ  <= 1'b0;
        end else begin
            rampSetQ     <= rampSetD;
            rampOutZeroQ <= rampOutZeroD;
            rampHoldQ    <= rampHoldD;
            rampInZeroQ  <= rampInZeroD;
        end
    end

    // ==============================================================
    // control authority
    logic localLockD;
    logic localLockQ;
    logic cmdTakeoverD;
    logic cmdTakeoverQ;
    logic refTakeoverD;
    logic refTakeoverQ;

    always_comb begin
        localLockD   = wordD[`DCWD_BIT_LOCAL_LOCK];
        cmdTakeoverD = wordD[`DCWD_BIT_CMD_TAKEOVER];
        refTakeoverD = wordD[`DCWD_BIT_REF_TAKEOVER];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            localLockQ   <= 1'b0;
            cmdTakeoverQ <= 1'b0;
            refTakeoverQ <= 1'b0;
        end else begin
            localLockQ   <= localLockD;
            cmdTakeoverQ <= cmdTakeoverD;
            refTakeoverQ <= refTakeoverD;
        end
    end

    // ==============================================================
    // user flags
    logic [`DCWD_USER_W-1:0] userFlagsD;
    logic [`DCWD_USER_W-1:0] userFlagsQ;

    always_comb begin
        userFlagsD = wordD[`DCWD_USER_MSB:`DCWD_USER_LSB];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            userFlagsQ <= '0;
        end else begin
            userFlagsQ <= userFlagsD;
        end
    end

    // ==============================================================
    // fault reset pulse
    logic faultResetD;
    logic faultResetQ;

    always_comb begin
        faultResetD = faultEdge(cmdWrite, cmdWord, wordQ, faultActive);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            faultResetQ <= 1'b0;
        end else begin
            faultResetQ <= faultResetD;
        end
    end

    // ==============================================================
    // outputs
    assign driveCommandWord = drvQ;
    assign driveCmd         = '{
        stopRequest:          stopReqQ,
        startRequest:         startReqQ,
        reverseDir:           reverseQ,
        extLocation:          locationQ,
        runEnable:            runEnableQ,
        stopMode:             stopModeQ,
        rampSet:              rampSetQ,
        rampOutZero:          rampOutZeroQ,
        rampHold:             rampHoldQ,
        rampInZero:           rampInZeroQ,
        localLock:            localLockQ,
        busCommandTakeover:   cmdTakeoverQ,
        busReferenceTakeover: refTakeoverQ,
        userFlags:            userFlagsQ
    };
    assign faultResetPulse  = faultResetQ;
    assign storedWord       = wordQ;

endmodule

/* File: dcwd_decoder_sva.sv */
// Purpose: port checks of the command word decoder
// Assumes: outputs move one edge after their cause
// Notes:   config terms are read one edge back
`timescale 1ns/100ps
module dcwd_decoder_sva
    import dcwd_pkg::*;
(
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            cmdWrite,
    input wire logic [31:0]     cmdWord,
    input wire logic            referenceNegative,
    input wire logic            faultActive,
    input wire logic            locationFromBus,
    input wire logic            runEnableFromBus,
    input wire logic            runEnableOther,
    input wire dcwd_stop_mode_t paramStopMode,
    input wire dcwd_ramp_set_t  otherRampSet,
    input wire logic [15:0]     driveCommandWord,
    input wire dcwd_cmd_t       driveCmd,
    input wire logic            faultResetPulse,
    input wire logic [31:0]     storedWord
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==============================================================
    // checks
    a_word_pass: assert property (cmdWrite |=> driveCommandWord == $past(cmdWord[15:0]))
        else $error("low half differs");
    a_stop_start: assert property (cmdWrite |=> driveCmd[17:16] == $past({cmdWord[0], cmdWord[1]}))
        else $error("stop or start wrong");
    a_dir_xor: assert property ($past(resetn) |-> driveCmd.reverseDir ==
        (storedWord[2] ^ $past(referenceNegative))) else $error("direction wrong");
    a_fault_edge: assert property ($past(resetn) |-> faultResetPulse == ($past(cmdWrite)
        & $past(cmdWord[4]) & ~$past(storedWord[4]) & $past(faultActive)))
        else $error("fault pulse wrong");
    a_run_enable: assert property ($past(resetn) |-> driveCmd.runEnable ==
        ($past(runEnableFromBus) ? ~storedWord[6] : $past(runEnableOther)))
        else $error("run enable wrong");
    a_stop_prio: assert property ($past(resetn) |-> driveCmd.stopMode == (storedWord[9]
        ? DCWD_STOP_FREEWHEEL : storedWord[8] ? DCWD_STOP_EMERGENCY_RAMP : storedWord[7]
        ? DCWD_STOP_NORMAL_RAMP : $past(paramStopMode))) else $error("stop mode wrong");
    a_ramp_set: assert property ($past(resetn) |-> driveCmd.rampSet == (storedWord[10]
        ? $past(otherRampSet) : DCWD_RAMP_SET_FIRST)) else $error("ramp set wrong");
    a_ramp_bits: assert property (cmdWrite |=> driveCmd[9:6] ==
        $past({cmdWord[11], cmdWord[12], cmdWord[13], cmdWord[14]}))
        else $error("ramp overrides wrong");
    a_user_take: assert property (cmdWrite |=> driveCmd[5:0] == $past({cmdWord[16],
        cmdWord[17], cmdWord[25:22]})) else $error("takeover or user flags wrong");
    a_location_pick: assert property ($past(resetn) |-> driveCmd.extLocation ==
        ($past(locationFromBus) ? storedWord[5] : $past(driveCmd.extLocation)))
        else $error("location wrong");
endmodule
bind dcwd_decoder dcwd_decoder_sva u_dcwd_decoder_sva (.*);

/* File: dcwd_decoder_tb.sv */
// Purpose: random and corner tests of the command word decoder
// Assumes: master model drives words at falling edges
// Notes:   location is tracked here as it holds when not bus-chosen
`timescale 1ns/100ps
module dcwd_decoder_tb
    import dcwd_pkg::*;
;
    logic            clk, resetn, cmdWrite, referenceNegative, faultActive, wr;
    logic            locationFromBus, runEnableFromBus, runEnableOther, faultResetPulse;
    logic [31:0]     cmdWord, storedWord, w, cur, prevWord;
    logic [15:0]     driveCommandWord;
    dcwd_stop_mode_t paramStopMode;
    dcwd_ramp_set_t  otherRampSet;
    dcwd_location_t  expLoc;
    dcwd_cmd_t       driveCmd, expV;
    int              fails, compares;
    dcwd_decoder u_dcwd_decoder (.*);
    dcwd_master_model u_dcwd_master_model (.*);
    // ==============================================================
    // expectation and reporting
    function automatic dcwd_cmd_t expCmd(logic [31:0] v);
        return '{v[0], v[1], v[2] ^ referenceNegative, expLoc,
                 runEnableFromBus ? ~v[6] : runEnableOther,
                 v[9] ? DCWD_STOP_FREEWHEEL : v[8] ? DCWD_STOP_EMERGENCY_RAMP
                 : v[7] ? DCWD_STOP_NORMAL_RAMP : paramStopMode,
                 v[10] ? otherRampSet : DCWD_RAMP_SET_FIRST,
                 v[11], v[12], v[13], v[14], v[16], v[17], v[25:22]};
    endfunction
    task automatic chk(string name, logic [31:0] seen, logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #100000;
        fails++;
        summarize();
    end
    // ==============================================================
    // main sequence
    initial begin
        {resetn, referenceNegative, faultActive, locationFromBus, runEnableFromBus} = 5'h0;
        {runEnableOther, fails, compares, prevWord} = '0;
        paramStopMode = DCWD_STOP_NORMAL_RAMP;
        otherRampSet = DCWD_RAMP_SET_FIRST;
        expLoc = DCWD_LOC_FIRST;
        void'($urandom(8));
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 400; i++) begin
            // a second reset in mid-run must clear every output again
            if (i == 300) begin
                resetn = 1'b0;
                u_dcwd_master_model.idle();
                chk("reset word", storedWord, 32'h0);
                chk("reset drive word", driveCommandWord, 32'h0);
                chk("reset cmd", driveCmd, 32'h0);
                chk("reset pulse", faultResetPulse, 32'h0);
                resetn = 1'b1;
                prevWord = '0;
                expLoc = DCWD_LOC_FIRST;
            end
            {referenceNegative, faultActive, locationFromBus, runEnableFromBus} = 4'($urandom);
            runEnableOther = 1'($urandom);
            paramStopMode = dcwd_stop_mode_t'($urandom_range(2));
            otherRampSet = dcwd_ramp_set_t'($urandom_range(1));
            // first words: every stop-bit mix with reserved bits 3, 18-21 and 26-31 set (bit 15 clear) and bit 4 toggling
            w = (i < 16) ? (32'hfc3c_0008 | (32'(i) << 7) | (32'(i & 1) << 4)) : $urandom;
            wr = (i % 5 != 4);
            if (wr) u_dcwd_master_model.send(w);
            else u_dcwd_master_model.idle();
            cur = wr ? w : prevWord;
            if (locationFromBus) expLoc = dcwd_location_t'(cur[5]);
            chk("stored word", storedWord, cur);
            chk("drive word", driveCommandWord, cur[15:0]);
            expV = expCmd(cur);
            chk("drive cmd upper", driveCmd[17:9], expV[17:9]);
            chk("drive cmd lower", driveCmd[8:0], expV[8:0]);
            chk("fault pulse", faultResetPulse, wr & cur[4] & ~prevWord[4] & faultActive);
            prevWord = cur;
        end
        summarize();
    end
endmodule

/* File: dcwd_master_model.sv */
// Purpose: fieldbus master that writes command words
// Assumes: one word per strobe, writes may run back to back
// Notes:   idle data is inverted so a stale word never looks live
`timescale 1ns/100ps
module dcwd_master_model (
    input  wire logic   clk,
    output logic        cmdWrite,
    output logic [31:0] cmdWord
);
    initial begin
        cmdWrite = 1'b0;
        cmdWord  = 32'h0;
    end
    // ==============================================================
    // transfers: word taken at the next rising edge, chain sends for back to back
    task automatic send(input logic [31:0] w);
        cmdWrite = 1'b1;
        cmdWord  = w;
        @(negedge clk);
    endtask
    task automatic idle();
        cmdWrite = 1'b0;
        cmdWord  = ~cmdWord;
        @(negedge clk);
    endtask
endmodule

/* File: dcwd_params.svh */
// Purpose: constants for the drive control word decoder
// Assumes: one 32-bit command word, bit positions fixed
// Notes:   included by its bare name
`ifndef DCWD_PARAMS_SVH
`define DCWD_PARAMS_SVH

// ==============================================================
// word layout
`define DCWD_WORD_W            32
`define DCWD_DRV_W             16
`define DCWD_WORD_RESET        32'h0000_0000
`define DCWD_BIT_STOP          0
`define DCWD_BIT_START         1
`define DCWD_BIT_REVERSE       2
`define DCWD_BIT_FAULT_RESET   4
`define DCWD_BIT_SECOND_LOC    5
`define DCWD_BIT_RUN_DISABLE   6
`define DCWD_BIT_NORMAL_STOP   7
`define DCWD_BIT_EMERG_STOP    8
`define DCWD_BIT_FREEWHEEL     9
`define DCWD_BIT_SECOND_RAMP   10
`define DCWD_BIT_RAMP_OUT_ZERO 11
`define DCWD_BIT_RAMP_HOLD     12
`define DCWD_BIT_RAMP_IN_ZERO  13
`define DCWD_BIT_LOCAL_LOCK    14
`define DCWD_BIT_CMD_TAKEOVER  16
`define DCWD_BIT_REF_TAKEOVER  17
`define DCWD_USER_LSB          22
`define DCWD_USER_MSB          25
`define DCWD_USER_W            4

`endif

/* File: dcwd_pkg.sv */
// Purpose: types for the drive control word decoder
// Assumes: dcwd_params.svh supplies all numbers
// Notes:   decoded command travels as one packed struct
`include "dcwd_params.svh"

package dcwd_pkg;

    // ==============================================================
    // stop modes, ramp sets and locations
    typedef enum logic [1:0] {
        DCWD_STOP_NORMAL_RAMP,
        DCWD_STOP_EMERGENCY_RAMP,
        DCWD_STOP_FREEWHEEL
    } dcwd_stop_mode_t;

    typedef enum logic {
        DCWD_RAMP_SET_FIRST,
        DCWD_RAMP_SET_SECOND
    } dcwd_ramp_set_t;

    typedef enum logic {
        DCWD_LOC_FIRST,
        DCWD_LOC_SECOND
    } dcwd_location_t;

    // ==============================================================
    // decoded drive command
    typedef struct packed {
        logic                         stopRequest;
        logic                         startRequest;
        logic                         reverseDir;
        dcwd_location_t               extLocation;
        logic                         runEnable;
        dcwd_stop_mode_t              stopMode;
        dcwd_ramp_set_t               rampSet;
        logic                         rampOutZero;
        logic                         rampHold;
        logic                         rampInZero;
        logic                         localLock;
        logic                         busCommandTakeover;
        logic                         busReferenceTakeover;
        logic [`DCWD_USER_W-1:0]      userFlags;
    } dcwd_cmd_t;

endpackage
